// ==== design/ipx_regs.vh ====
`ifndef IPX_REGS_VH
`define IPX_REGS_VH
// register indices; byte address is four times the index
`define IPX_IDX_REF_CTRL 12'h130
`define IPX_IDX_PULLUP 12'h136
`define IPX_IDX_SRC0 12'h138
`define IPX_IDX_SRC_STEP 12'h002
`define IPX_NUM_SRC 4
// field positions
`define IPX_PULLUP_MSB 8
`define IPX_PIN_MSB 12
`define IPX_PIN_LSB 8
`define IPX_MAG_MSB 2
`define IPX_MAG_LSB 0
`define IPX_REF_EN_BIT 0
// reset values
`define IPX_PULLUP_RST 16'h0000
`define IPX_SRC_RST 16'h0000
`define IPX_REF_RST 16'h0001
// pin-select codes
`define IPX_PIN_AIN_LAST 5'h08
`define IPX_PIN_GPIO_FIRST 5'h11
`define IPX_PIN_GPIO_LAST 5'h14
`endif

// ==== design/ipx_pullup_excitation.v ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "ipx_regs.vh"
// What this block does
// RQ1 - bit n of pull-up register enables weak pull-up on analog input n, n 0..8
// RQ2 - pull-up register resets to zero; bits 15:9 reserved but read/write
// RQ3 - four independent excitation sources, each with own pin and value register
// RQ4 - pin codes 0..8 route current to analog input 0..8; others reserved
// RQ5 - pin codes 10001..10100 route current to general-purpose pins 0..3
// RQ6 - value field bits 2:0 selects magnitude, 0 up to 1500 microamps
// RQ7 - software enables internal reference before using any excitation source
// RQ8 - software pairs sources 0 with 1 and 2 with 3 for matching
// RQ9 - source registers at 0x138 step two, reset zero; 15:13 and 7:3 read zero
// RQ10 - reference control bit 0 enables internal reference, resets to one
// RQ11 - read/write fields return last write; read-only reserved read zero
module ipx_pullup_excitation #(
	parameter NSRC = `IPX_NUM_SRC
) (
	input wire mclk,
	input wire srst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [13:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	output reg [8:0] pullupEnable,
	output reg refEnable,
	output reg [NSRC*9-1:0] sourceAinRoute,
	output reg [NSRC*4-1:0] sourceGpioRoute,
	output reg [NSRC*3-1:0] sourceMagnitude,
	output reg [NSRC-1:0] sourceActive
);
	// constants fixed to their widths once, so nothing pads or cuts silently
	localparam [15:0] PULLUP_RST = `IPX_PULLUP_RST;
	localparam [15:0] SRC_RST = `IPX_SRC_RST;
	localparam [15:0] REF_RST = `IPX_REF_RST;
	localparam [11:0] IDX_PULLUP = `IPX_IDX_PULLUP;
	localparam [11:0] IDX_REF = `IPX_IDX_REF_CTRL;
	localparam [11:0] IDX_SRC0 = `IPX_IDX_SRC0;
	localparam [11:0] IDX_STEP = `IPX_IDX_SRC_STEP;
	localparam [4:0] PIN_AIN_LAST = `IPX_PIN_AIN_LAST;
	localparam [4:0] PIN_GPIO_FIRST = `IPX_PIN_GPIO_FIRST;
	localparam [4:0] PIN_GPIO_LAST = `IPX_PIN_GPIO_LAST;

	reg [15:0] pullupReg;
	reg refEnReg;
	reg [15:0] srcRdata;
	reg [15:0] next_rdata;
	wire [11:0] idx;
	wire req;
	wire wrReq;
	wire pullupHit;
	wire refHit;
	wire hit;
	wire [NSRC-1:0] srcHit;
	wire [NSRC*16-1:0] srcRdFlat;
	wire [NSRC*9-1:0] next_ainRoute;
	wire [NSRC*4-1:0] next_gpioRoute;
	wire [NSRC*3-1:0] next_magnitude;
	wire [NSRC-1:0] next_active;
	integer k;

	// word index of the bus address matches a register
	function indexHit;
		input [11:0] index;
		input [11:0] target;
		begin
			indexHit = (index == target);
		end
	endfunction

	// merge written byte lanes into the old value
	function [15:0] laneMerge;
		input [15:0] old;
		input [15:0] din;
		input [1:0] sel;
		begin
			laneMerge = {sel[1] ? din[15:8] : old[15:8], sel[0] ? din[7:0] : old[7:0]};
		end
	endfunction

	// pin code names an analog input
	function pinIsAin;
		input [4:0] code;
		begin
			pinIsAin = (code <= PIN_AIN_LAST);
		end
	endfunction

	// pin code names a general-purpose pin
	function pinIsGpio;
		input [4:0] code;
		begin
			pinIsGpio = (code >= PIN_GPIO_FIRST) && (code <= PIN_GPIO_LAST);
		end
	endfunction

	assign idx = wb_adr_i[13:2];
	// a pending ack or err keeps a held strobe from being taken twice
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wrReq = req & wb_we_i;
	assign pullupHit = indexHit(idx, IDX_PULLUP);
	assign refHit = indexHit(idx, IDX_REF);
	assign hit = pullupHit | refHit | (|srcHit);

	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : gen_src
			localparam [31:0] SRC_IDX_FULL = IDX_SRC0 + g * IDX_STEP;
			localparam [11:0] SRC_IDX = SRC_IDX_FULL[11:0];
			reg [4:0] pinSel;
			reg [2:0] magSel;
			wire [15:0] oldWord;
			wire [15:0] newWord;
			wire [2:0] gpioIdx;
			wire pinValid;

			assign srcHit[g] = indexHit(idx, SRC_IDX); // RQ9
			// reserved bits are rebuilt as zero, so writes to them are lost
			assign oldWord = {3'h0, pinSel, 5'h00, magSel};
			assign newWord = laneMerge(oldWord, wb_dat_i[15:0], wb_sel_i[1:0]);
			assign srcRdFlat[g*16 +: 16] = srcHit[g] ? oldWord : 16'h0000; // RQ11
			assign gpioIdx = pinSel[2:0] - 3'h1;
			assign pinValid = pinIsAin(pinSel) | pinIsGpio(pinSel);

			always @(posedge mclk) begin
				if (srst) begin
					pinSel <= SRC_RST[`IPX_PIN_MSB:`IPX_PIN_LSB]; // RQ9
					magSel <= SRC_RST[`IPX_MAG_MSB:`IPX_MAG_LSB]; // RQ9
				end else if (wrReq & srcHit[g]) begin
					pinSel <= newWord[`IPX_PIN_MSB:`IPX_PIN_LSB]; // RQ3
					magSel <= newWord[`IPX_MAG_MSB:`IPX_MAG_LSB]; // RQ6
				end
			end

			// a reserved pin code is kept for read-back but routes nowhere
			assign next_ainRoute[g*9 +: 9] = pinIsAin(pinSel) ?
				(9'h001 << pinSel[3:0]) : 9'h000; // RQ4
			assign next_gpioRoute[g*4 +: 4] = pinIsGpio(pinSel) ?
				(4'h1 << gpioIdx) : 4'h0; // RQ5
			assign next_magnitude[g*3 +: 3] = magSel; // RQ6
			// without the reference the current is off value, so gate it
			assign next_active[g] = (magSel != 3'h0) & refEnReg & pinValid; // RQ7
		end
	endgenerate

	// only one source can match, so an or of all lanes is the read mux
	always @* begin
		srcRdata = 16'h0000;
		for (k = 0; k < NSRC; k = k + 1) begin
			srcRdata = srcRdata | srcRdFlat[k*16 +: 16];
		end
	end

	always @* begin
		next_rdata = 16'h0000;
		if (pullupHit) begin
			next_rdata = pullupReg; // RQ11
		end else if (refHit) begin
			next_rdata = {15'h0000, refEnReg}; // RQ10
		end else if (|srcHit) begin
			next_rdata = srcRdata; // RQ11
		end
	end

	// one-cycle answer; unmapped indices get err so the bus never hangs
	always @(posedge mclk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & hit;
			wb_err_o <= req & ~hit;
			wb_dat_o <= {16'h0000, next_rdata};
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			pullupReg <= PULLUP_RST; // RQ2
		end else if (wrReq & pullupHit) begin
			pullupReg <= laneMerge(pullupReg, wb_dat_i[15:0], wb_sel_i[1:0]); // RQ2
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			refEnReg <= REF_RST[`IPX_REF_EN_BIT]; // RQ10
		end else if (wrReq & refHit & wb_sel_i[0]) begin
			refEnReg <= wb_dat_i[`IPX_REF_EN_BIT]; // RQ10
		end
	end

	// analog controls lag the register write by one cycle
	always @(posedge mclk) begin
		if (srst) begin
			pullupEnable <= PULLUP_RST[`IPX_PULLUP_MSB:0];
			refEnable <= REF_RST[`IPX_REF_EN_BIT];
		end else begin
			pullupEnable <= pullupReg[`IPX_PULLUP_MSB:0]; // RQ1
			refEnable <= refEnReg; // RQ10
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			sourceAinRoute <= {NSRC*9{1'b0}};
			sourceGpioRoute <= {NSRC*4{1'b0}};
			sourceMagnitude <= {NSRC*3{1'b0}};
			sourceActive <= {NSRC{1'b0}};
		end else begin
			sourceAinRoute <= next_ainRoute; // RQ4
			sourceGpioRoute <= next_gpioRoute; // RQ5
			sourceMagnitude <= next_magnitude; // RQ6
			sourceActive <= next_active; // RQ3
		end
	end
endmodule

// ==== tb/ipx_chk_assertions.sv ====
`timescale 1ns/1ps
module ipx_chk(
	input wire mclk,
	input wire srst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [13:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire [8:0] pullupEnable,
	input wire refEnable,
	input wire [11:0] sourceMagnitude
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// full low-half writes only, partial lanes keep old bits
	wire wr = wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3;
	property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
		|=> wb_ack_o ^ wb_err_o; endproperty
	a_take: assert property (p_take) else $error("no answer");
	property p_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_one: assert property (p_one) else $error("long ack");
	property p_pu; wr && wb_adr_i == 14'h4d8 |=> pullupEnable == $past(wb_dat_i[8:0]); endproperty
	a_pu: assert property (p_pu) else $error("pullup");
	property p_mag; wr && wb_adr_i == 14'h4e0
		|=> sourceMagnitude[2:0] == $past(wb_dat_i[2:0]); endproperty
	a_mag: assert property (p_mag) else $error("magnitude");
	property p_ref; wr && wb_adr_i == 14'h4c0 |=> refEnable == $past(wb_dat_i[0]); endproperty
	a_ref: assert property (p_ref) else $error("ref");
	property p_rsv; wb_ack_o && !wb_we_i && wb_adr_i[13:5] == 9'h27
		|-> wb_dat_o[15:13] == 3'h0 && wb_dat_o[7:3] == 5'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved");
	property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper half");
	property p_rst; $fell(srst) |-> pullupEnable == 9'h0 && refEnable; endproperty
	a_rst: assert property (p_rst) else $error("reset");
endmodule
bind ipx_pullup_excitation ipx_chk ipx_chk_i(
	.mclk(mclk),
	.srst(srst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o),
	.pullupEnable(pullupEnable),
	.refEnable(refEnable),
	.sourceMagnitude(sourceMagnitude)
);

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	localparam logic [13:0] A_REF = 14'h04c0;
	localparam logic [13:0] A_PU = 14'h04d8;
	localparam logic [13:0] A_SRC0 = 14'h04e0;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [13:0] wb_adr_i = 14'h0000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic wb_err_o;
	logic [8:0] pullupEnable;
	logic refEnable;
	logic [35:0] sourceAinRoute;
	logic [15:0] sourceGpioRoute;
	logic [11:0] sourceMagnitude;
	logic [3:0] sourceActive;
	logic [31:0] rdv;
	logic rerr;
	int bad_count = 0;
	int tests_run = 0;
	always #4 mclk = ~mclk;
	ipx_pullup_excitation ipx_pullup_excitation_i(
		.mclk(mclk),
		.srst(srst),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o),
		.pullupEnable(pullupEnable),
		.refEnable(refEnable),
		.sourceAinRoute(sourceAinRoute),
		.sourceGpioRoute(sourceGpioRoute),
		.sourceMagnitude(sourceMagnitude),
		.sourceActive(sourceActive)
	);
	// classic cycle: hold everything until ack or err is sampled high
	task bus(input logic w, input logic [13:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		@(posedge mclk);
		// only the watchdog ends a hang
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge mclk);
		rerr = wb_err_o;
		rdv = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task chk(input string s, input logic [35:0] e, input logic [35:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	task t_regs;
		bus(1'b0, A_PU, 4'h3, 32'h0);
		chk("pullup reset", 36'h0, rdv);
		chk("read ack", 36'h0, rerr);
		bus(1'b1, A_PU, 4'h3, 32'hffff);
		bus(1'b0, A_PU, 4'h3, 32'h0);
		chk("pullup", 36'hffff, rdv);
		chk("pullupEnable", 36'h1ff, pullupEnable);
		bus(1'b1, A_PU, 4'h1, 32'h0000);
		bus(1'b0, A_PU, 4'h3, 32'h0);
		chk("pullup lane", 36'hff00, rdv);
		chk("pullupEnable lane", 36'h100, pullupEnable);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, A_SRC0 + 14'(8 * i), 4'h3, 32'h0);
			chk("source reset", 36'h0, rdv);
			bus(1'b1, A_SRC0 + 14'(8 * i), 4'h3, 32'hffff);
			bus(1'b0, A_SRC0 + 14'(8 * i), 4'h3, 32'h0);
			chk("source", 36'h1f07, rdv);
			chk("reserved ain", 36'h0, sourceAinRoute[9 * i +: 9]);
			chk("reserved gpio", 36'h0, sourceGpioRoute[4 * i +: 4]);
		end
		bus(1'b0, 14'h04c4, 4'h3, 32'h0);
		chk("unmapped err", 36'h1, rerr);
		$display("registers done");
	endtask
	task t_route;
		bus(1'b1, A_REF, 4'h3, 32'h1);
		bus(1'b0, A_REF, 4'h3, 32'h0);
		chk("refctl", 36'h1, rdv);
		bus(1'b1, A_SRC0, 4'h3, 32'h0807);
		chk("ain", 36'h100, sourceAinRoute[8:0]);
		chk("active", 36'h1, sourceActive[0]);
		bus(1'b1, A_SRC0, 4'h3, 32'h0907);
		chk("reserved pin", 36'h0, sourceAinRoute[8:0]);
		chk("reserved active", 36'h0, sourceActive[0]);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, A_SRC0, 4'h3, 32'(((17 + c) << 8) + 1));
			chk("gpio", 36'(1 << c), sourceGpioRoute[3:0]);
			chk("gpio ain", 36'h0, sourceAinRoute[8:0]);
		end
		for (int v = 0; v < 8; v++) begin
			bus(1'b1, A_SRC0 + 14'h008, 4'h3, 32'(v));
			chk("magnitude", 36'(v), sourceMagnitude[5:3]);
		end
		chk("magnitude0", 36'h1, sourceMagnitude[2:0]);
		bus(1'b1, A_SRC0 + 14'h010, 4'h3, 32'h0203);
		bus(1'b1, A_SRC0 + 14'h018, 4'h3, 32'h0303);
		chk("pair magnitude", 36'h1b, sourceMagnitude[11:6]);
		chk("pair route", 36'h1004, sourceAinRoute[35:18]);
		chk("pair active", 36'hf, sourceActive);
		bus(1'b1, A_REF, 4'h3, 32'hfffe);
		bus(1'b0, A_REF, 4'h3, 32'h0);
		chk("refctl", 36'h0, rdv);
		chk("refEnable", 36'h0, refEnable);
		chk("active no ref", 36'h0, sourceActive);
		bus(1'b1, A_REF, 4'h3, 32'h1);
		chk("active ref", 36'hf, sourceActive);
		$display("routing done");
	endtask
	task t_reset;
		@(posedge mclk);
		srst <= 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		chk("pullupEnable reset", 36'h0, pullupEnable);
		chk("refEnable reset", 36'h1, refEnable);
		chk("active reset", 36'h0, sourceActive);
		bus(1'b0, A_PU, 4'h3, 32'h0);
		chk("pullup reset", 36'h0, rdv);
		bus(1'b0, A_SRC0 + 14'h008, 4'h3, 32'h0);
		chk("source reset", 36'h0, rdv);
		bus(1'b0, A_REF, 4'h3, 32'h0);
		chk("refctl reset", 36'h1, rdv);
		$display("reset done");
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		t_regs;
		t_route;
		t_reset;
		end_of_test;
	end
	initial begin
		#20000;
		bad_count++;
		end_of_test;
	end
endmodule
